//--- shared/bsc_defines.svh
// Constants for the control-packet interpreter of the copy engine.
// Included by the interpreter and its testbench; definitions only.
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH
`define BSC_TYPE_MSB 31
`define BSC_TYPE_LSB 29
`define BSC_TYPE_CTRL 3'h0
`define BSC_OP_MSB 28
`define BSC_OP_LSB 23
`define BSC_OP_STORE_IMM 6'h20
`define BSC_OP_STORE_IDX 6'h21
`define BSC_OP_FLUSH_HOLD 6'h0b
`define BSC_OP_TT_UPDATE 6'h23
`define BSC_OP_SW_INT 6'h02
`define BSC_GLOBAL_BIT 22
`define BSC_PROC_PAGE_BIT 21
`define BSC_HOLD_BIT 0
`define BSC_LEN_DWORD 8'h02
`define BSC_LEN_QWORD 8'h03
`define BSC_TT_LEN_MAX 6'h3d
`define BSC_IDX_MSB 11
`define BSC_IDX_LSB 2
`define BSC_ENTRY_MSB 31
`define BSC_ENTRY_LSB 12
`endif

//--- shared/bsc_pkg.sv
// Types for the control-packet interpreter.
// Assumes bsc_defines.svh sits on the include path.
package bsc_pkg;
  typedef enum logic [6:0] {
    BSC_IDLE = 7'h01,
    BSC_HDR1 = 7'h02,
    BSC_ADDR = 7'h04,
    BSC_DATA0 = 7'h08,
    BSC_DATA1 = 7'h10,
    BSC_TT_LO = 7'h20,
    BSC_TT_HI = 7'h40
  } bsc_state_t;
  typedef enum logic [1:0] {
    BSC_K_IMM = 2'h0,
    BSC_K_IDX = 2'h1,
    BSC_K_TT = 2'h2
  } bsc_kind_t;
endpackage : bsc_pkg

//--- rtl/bsc_hold_flag.sv
// Hold flag for register and I/O flushes.
// Assumes flush requests and the packet decode arrive on i_clk.
`timescale 1ns/1ps
module bsc_hold_flag
  import bsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_value,
  input wire logic i_reg_flush_req,
  input wire logic i_io_flush_req,
  output logic o_hold,
  output logic o_reg_flush,
  output logic o_io_flush
);
  typedef struct packed {
    logic hold;
    logic reg_flush;
    logic io_flush;
  } bsc_hold_t;
  bsc_hold_t s_reg;
  bsc_hold_t s_next;
  always_comb begin
    s_next = s_reg;
    if (i_load) begin
      s_next.hold = i_value;
    end
    s_next.reg_flush = i_reg_flush_req & ~s_reg.hold;
    s_next.io_flush = i_io_flush_req & ~s_reg.hold;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_hold = s_reg.hold;
  assign o_reg_flush = s_reg.reg_flush;
  assign o_io_flush = s_reg.io_flush;
  a_hold_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
    s_reg.hold |=> !s_reg.reg_flush && !s_reg.io_flush)
    else $error("flush passed while held");
endmodule : bsc_hold_flag

//--- rtl/bsc_ctrl_cmd.sv
// Control-packet interpreter of the copy engine command stream.
// Assumes one dword per i_dw_valid from the command buffer and a write port that never stalls.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_ctrl_cmd
  import bsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_dw_valid,
  input wire logic [31:0] i_dw,
  input wire logic i_privileged,
  input wire logic [31:0] i_ctx_base,
  input wire logic i_reg_flush_req,
  input wire logic i_io_flush_req,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [63:0] o_mem_data,
  output logic o_mem_qword,
  output logic o_mem_global,
  output logic o_mem_status,
  output logic o_mem_proc_page,
  output logic o_tt_wr,
  output logic [19:0] o_tt_index,
  output logic [31:0] o_tt_data,
  output logic o_user_int,
  output logic o_tt_error,
  output logic o_flush_hold,
  output logic o_reg_flush,
  output logic o_io_flush,
  output logic o_busy
);
  typedef struct packed {
    bsc_state_t state;
    bsc_kind_t kind;
    logic qword;
    logic global_sel;
    logic proc_page;
    logic [5:0] tt_left;
    logic tt_first;
    logic [31:0] tt_lo;
    logic mem_wr;
    logic [31:0] mem_addr;
    logic [63:0] mem_data;
    logic mem_qword;
    logic mem_global;
    logic mem_status;
    logic mem_proc_page;
    logic tt_wr;
    logic [19:0] tt_index;
    logic [31:0] tt_data;
    logic user_int;
    logic tt_error;
    logic busy;
    logic [31:0] st_addr;
    logic [31:0] st_lo;
  } bsc_core_t;
  bsc_core_t c_reg;
  bsc_core_t c_next;
  logic hold_load;
  logic hold_value;
  logic is_ctrl;
  logic [5:0] opcode;
  assign is_ctrl = i_dw[`BSC_TYPE_MSB:`BSC_TYPE_LSB] == `BSC_TYPE_CTRL;
  assign opcode = i_dw[`BSC_OP_MSB:`BSC_OP_LSB];
  always_comb begin
    c_next = c_reg;
    c_next.mem_wr = 1'b0;
    c_next.tt_wr = 1'b0;
    c_next.user_int = 1'b0;
    c_next.tt_error = 1'b0;
    hold_load = 1'b0;
    hold_value = 1'b0;
    if (i_dw_valid) begin
      unique case (c_reg.state)
        BSC_IDLE: begin
          if (is_ctrl) begin
            if (opcode == `BSC_OP_STORE_IMM) begin
              c_next.kind = BSC_K_IMM;
              c_next.qword = i_dw[7:0] == `BSC_LEN_QWORD;
              c_next.global_sel = i_dw[`BSC_GLOBAL_BIT] & i_privileged;
              c_next.proc_page = 1'b0;
              c_next.state = BSC_HDR1;
            end else if (opcode == `BSC_OP_STORE_IDX) begin
              c_next.kind = BSC_K_IDX;
              c_next.qword = i_dw[7:0] == `BSC_LEN_QWORD;
              c_next.proc_page = i_dw[`BSC_PROC_PAGE_BIT];
              c_next.global_sel = 1'b0;
              c_next.state = BSC_ADDR;
            end else if (opcode == `BSC_OP_FLUSH_HOLD) begin
              hold_load = 1'b1;
              hold_value = i_dw[`BSC_HOLD_BIT];
            end else if (opcode == `BSC_OP_TT_UPDATE) begin
              c_next.kind = BSC_K_TT;
              c_next.tt_left = (i_dw[5:0] > `BSC_TT_LEN_MAX) ? `BSC_TT_LEN_MAX : i_dw[5:0];
              c_next.tt_first = 1'b1;
              c_next.global_sel = i_privileged;
              c_next.tt_error = ~i_privileged;
              // The count holds the payload dwords still to come, less one, as the length field does.
              c_next.state = BSC_TT_LO;
            end else if (opcode == `BSC_OP_SW_INT) begin
              c_next.user_int = 1'b1;
            end
          end
        end
        BSC_HDR1: begin
          c_next.state = BSC_ADDR;
        end
        // Address and low dword wait in st_addr and st_lo, so the store outputs hold until the next write.
        BSC_ADDR: begin
          if (c_reg.kind == BSC_K_IDX) begin
            c_next.st_addr = {20'h00000, i_dw[`BSC_IDX_MSB:`BSC_IDX_LSB], 2'h0};
          end else begin
            c_next.st_addr = {i_dw[31:2], 2'h0};
          end
          c_next.state = BSC_DATA0;
        end
        BSC_DATA0: begin
          c_next.st_lo = i_dw;
          if (c_reg.qword) begin
            c_next.state = BSC_DATA1;
          end else begin
            c_next.state = BSC_IDLE;
            c_next.mem_wr = 1'b1;
            c_next.mem_data = {32'h00000000, i_dw};
          end
        end
        BSC_DATA1: begin
          c_next.mem_data = {i_dw, c_reg.st_lo};
          c_next.state = BSC_IDLE;
          c_next.mem_wr = 1'b1;
        end
        BSC_TT_LO: begin
          c_next.tt_lo = i_dw;
          if (c_reg.tt_left == 6'h00) begin
            // An odd closing dword has no partner and is dropped.
            c_next.state = BSC_IDLE;
          end else begin
            c_next.tt_left = c_reg.tt_left - 6'h01;
            c_next.state = BSC_TT_HI;
          end
        end
        BSC_TT_HI: begin
          c_next.tt_data = c_reg.tt_lo;
          if (c_reg.tt_first) begin
            c_next.tt_index = i_dw[`BSC_ENTRY_MSB:`BSC_ENTRY_LSB];
          end else begin
            c_next.tt_index = c_reg.tt_index + 20'h00001;
          end
          c_next.tt_first = 1'b0;
          c_next.tt_wr = c_reg.global_sel;
          if (c_reg.tt_left == 6'h00) begin
            c_next.state = BSC_IDLE;
          end else begin
            c_next.tt_left = c_reg.tt_left - 6'h01;
            c_next.state = BSC_TT_LO;
          end
        end
        default: begin
          c_next.state = BSC_IDLE;
        end
      endcase
    end
    if (c_next.mem_wr) begin
      c_next.mem_qword = c_reg.qword;
      c_next.mem_global = c_reg.global_sel;
      c_next.mem_status = c_reg.kind == BSC_K_IDX;
      c_next.mem_proc_page = c_reg.proc_page;
      c_next.mem_addr = c_reg.st_addr;
      if (c_reg.kind == BSC_K_IDX && c_reg.proc_page) begin
        c_next.mem_addr = c_reg.st_addr + i_ctx_base;
      end
    end
    c_next.busy = c_next.state != BSC_IDLE;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      c_reg <= '{state: BSC_IDLE, kind: BSC_K_IMM, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end
  bsc_hold_flag u_hold (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(hold_load),
    .i_value(hold_value),
    .i_reg_flush_req(i_reg_flush_req),
    .i_io_flush_req(i_io_flush_req),
    .o_hold(o_flush_hold),
    .o_reg_flush(o_reg_flush),
    .o_io_flush(o_io_flush)
  );
  assign o_mem_wr = c_reg.mem_wr;
  assign o_mem_addr = c_reg.mem_addr;
  assign o_mem_data = c_reg.mem_data;
  assign o_mem_qword = c_reg.mem_qword;
  assign o_mem_global = c_reg.mem_global;
  assign o_mem_status = c_reg.mem_status;
  assign o_mem_proc_page = c_reg.mem_proc_page;
  assign o_tt_wr = c_reg.tt_wr;
  assign o_tt_index = c_reg.tt_index;
  assign o_tt_data = c_reg.tt_data;
  assign o_user_int = c_reg.user_int;
  assign o_tt_error = c_reg.tt_error;
  assign o_busy = c_reg.busy;
  sequence s_imm_hdr;
    i_dw_valid && c_reg.state == BSC_IDLE && is_ctrl && opcode == `BSC_OP_STORE_IMM;
  endsequence
  sequence s_int_hdr;
    i_dw_valid && c_reg.state == BSC_IDLE && is_ctrl && opcode == `BSC_OP_SW_INT;
  endsequence
  sequence s_qw_pair;
    i_dw_valid && c_reg.state == BSC_DATA0 && c_reg.qword ##1 i_dw_valid && c_reg.state == BSC_DATA1;
  endsequence
  sequence s_tt_pair;
    i_dw_valid && c_reg.state == BSC_TT_LO ##1 i_dw_valid && c_reg.state == BSC_TT_HI;
  endsequence
  a_global_priv: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_imm_hdr and i_privileged) |=> c_reg.global_sel == $past(i_dw[`BSC_GLOBAL_BIT]))
    else $error("global select not taken from header");
  a_store_dword: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_DATA0 && !c_reg.qword) |=> o_mem_wr && !o_mem_qword && o_mem_data == {32'h00000000, $past(i_dw)})
    else $error("single dword store wrong");
  a_qw_order: assert property (@(posedge i_clk) disable iff (i_rst)
    s_qw_pair |=> o_mem_qword && o_mem_data == {$past(i_dw), $past(i_dw, 2)})
    else $error("quadword halves swapped");
  a_status_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    o_mem_wr && o_mem_status |-> o_mem_addr == $past(c_reg.st_addr) + (o_mem_proc_page ? $past(i_ctx_base) : 32'h0))
    else $error("status page address wrong");
  a_hold_load: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_IDLE && is_ctrl && opcode == `BSC_OP_FLUSH_HOLD)
    |=> o_flush_hold == $past(i_dw[`BSC_HOLD_BIT]))
    else $error("flush hold not loaded");
  a_tt_opcode: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_IDLE && is_ctrl && opcode == `BSC_OP_TT_UPDATE && i_privileged)
    |=> c_reg.state == BSC_TT_LO && !o_tt_error)
    else $error("table update not recognised");
  a_tt_first: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_TT_HI && c_reg.tt_first) |=> o_tt_index == $past(i_dw[`BSC_ENTRY_MSB:`BSC_ENTRY_LSB]))
    else $error("first table index wrong");
  a_tt_data: assert property (@(posedge i_clk) disable iff (i_rst)
    s_tt_pair |=> o_tt_data == $past(i_dw, 2))
    else $error("table entry data wrong");
  a_no_stall: assert property (@(posedge i_clk) disable iff (i_rst)
    s_int_hdr ##1 s_imm_hdr |=> c_reg.state == BSC_HDR1)
    else $error("parser stalled after user interrupt");
  a_imm_unpriv: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_imm_hdr and !i_privileged) |=> !c_reg.global_sel)
    else $error("global select kept in unprivileged batch");
  a_imm_length: assert property (@(posedge i_clk) disable iff (i_rst)
    s_imm_hdr |=> c_reg.qword == ($past(i_dw[7:0]) == `BSC_LEN_QWORD))
    else $error("store length decode wrong");
  a_addr_align: assert property (@(posedge i_clk) disable iff (i_rst)
    o_mem_wr && !o_mem_status |-> o_mem_addr[1:0] == 2'h0)
    else $error("store address low bits set");
  a_qw_halves: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_DATA1) |=> o_mem_wr && o_mem_data[63:32] == $past(i_dw))
    else $error("upper dword misplaced");
  a_non_ctrl: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_IDLE && !is_ctrl) |=> !o_busy && !o_user_int)
    else $error("non-control header decoded");
  a_proc_page: assert property (@(posedge i_clk) disable iff (i_rst)
    o_mem_wr && o_mem_status |-> o_mem_proc_page == c_reg.proc_page)
    else $error("status page select lost");
  a_tt_unpriv: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_IDLE && is_ctrl && opcode == `BSC_OP_TT_UPDATE && !i_privileged)
    |=> o_tt_error ##1 (!o_tt_wr throughout (o_busy [*1]))) 
    else $error("unprivileged table update acted");
  a_tt_len: assert property (@(posedge i_clk) disable iff (i_rst)
    c_reg.tt_left <= `BSC_TT_LEN_MAX)
    else $error("table length above limit");
  a_tt_consec: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dw_valid && c_reg.state == BSC_TT_HI && !c_reg.tt_first) |=> o_tt_index == $past(o_tt_index) + 20'h00001)
    else $error("table entries not consecutive");
  a_user_int: assert property (@(posedge i_clk) disable iff (i_rst)
    s_int_hdr |=> o_user_int && !o_busy)
    else $error("user interrupt not raised");
endmodule : bsc_ctrl_cmd

//--- verification/bsc_fabric_model.sv
// Far-side model: memory, translation table and event counters for the interpreter.
// Assumes the design's write and event ports never need to wait.
`timescale 1ns/1ps
module bsc_fabric_model (
  input wire logic i_clk,
  input wire logic i_mem_wr,
  input wire logic [31:0] i_mem_addr,
  input wire logic [63:0] i_mem_data,
  input wire logic i_mem_qword,
  input wire logic [2:0] i_mem_kind,
  input wire logic i_tt_wr,
  input wire logic [19:0] i_tt_index,
  input wire logic [31:0] i_tt_data,
  input wire logic [3:0] i_events
);
  logic [31:0] mem [int];
  logic [31:0] tt [int];
  logic [2:0] kind_reg;
  int n_wr = 0;
  int n_ev [4] = '{0, 0, 0, 0};
  always @(posedge i_clk) begin
    if (i_mem_wr) begin
      mem[i_mem_addr[31:2]] = i_mem_data[31:0];
      if (i_mem_qword) begin
        mem[i_mem_addr[31:2] + 30'h1] = i_mem_data[63:32];
      end
      kind_reg <= i_mem_kind;
      n_wr++;
    end
    if (i_tt_wr) begin
      tt[i_tt_index] = i_tt_data;
      n_wr++;
    end
    for (int k = 0; k < 4; k++) begin
      if (i_events[k]) n_ev[k]++;
    end
  end
endmodule : bsc_fabric_model

//--- verification/bsc_ctrl_cmd_tb.sv
// Self-checking bench for the control-packet interpreter.
// Assumes the fabric model sits on the write ports and bsc_defines.svh is on the include path.
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_ctrl_cmd_tb;
  logic i_clk = 0, i_rst = 1, i_dw_valid = 0, i_privileged = 1, i_reg_flush_req = 0, i_io_flush_req = 0;
  logic [31:0] i_dw = 0, i_ctx_base = 0, o_mem_addr, o_tt_data;
  logic [63:0] o_mem_data;
  logic [19:0] o_tt_index;
  logic o_mem_wr, o_mem_qword, o_mem_global, o_mem_status, o_mem_proc_page, o_tt_wr;
  logic o_user_int, o_tt_error, o_flush_hold, o_reg_flush, o_io_flush, o_busy;
  logic [31:0] rs = 32'hb673;
  int errors = 0, samples_checked = 0, exp_wr = 0;
  int exp_ev [4] = '{0, 0, 0, 0};
  always #25 i_clk = ~i_clk;
  bsc_ctrl_cmd bsc_ctrl_cmd_i (.i_clk(i_clk), .i_rst(i_rst), .i_dw_valid(i_dw_valid), .i_dw(i_dw),
    .i_privileged(i_privileged), .i_ctx_base(i_ctx_base), .i_reg_flush_req(i_reg_flush_req),
    .i_io_flush_req(i_io_flush_req), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data),
    .o_mem_qword(o_mem_qword), .o_mem_global(o_mem_global), .o_mem_status(o_mem_status),
    .o_mem_proc_page(o_mem_proc_page), .o_tt_wr(o_tt_wr), .o_tt_index(o_tt_index), .o_tt_data(o_tt_data),
    .o_user_int(o_user_int), .o_tt_error(o_tt_error), .o_flush_hold(o_flush_hold),
    .o_reg_flush(o_reg_flush), .o_io_flush(o_io_flush), .o_busy(o_busy));
  bsc_fabric_model fab_i (.i_clk(i_clk), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr), .i_mem_data(o_mem_data),
    .i_mem_qword(o_mem_qword), .i_mem_kind({o_mem_global, o_mem_status, o_mem_proc_page}), .i_tt_wr(o_tt_wr),
    .i_tt_index(o_tt_index), .i_tt_data(o_tt_data), .i_events({o_io_flush, o_reg_flush, o_tt_error, o_user_int}));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [31:0] d);
    @(posedge i_clk);
    i_dw_valid <= 1'b1;
    i_dw <= d;
  endtask : send
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_dw_valid <= 1'b0;
      i_dw <= xs();
      i_reg_flush_req <= 1'b0;
      i_io_flush_req <= 1'b0;
    end
  endtask : idle
  // Polls the model's write count, then steps past the edge so its registered fields have landed.
  task automatic wait_wr();
    int n;
    n = 0;
    while (fab_i.n_wr != exp_wr && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    if (n == 20) begin
      errors++;
      $display("CHECK FAILED at %0t: writes %h expected %h", $time, fab_i.n_wr, exp_wr);
      finish_test();
    end
  endtask : wait_wr
  task automatic end_test(input string name);
    idle(3);
    wait_wr();
    for (int k = 0; k < 4; k++) check(fab_i.n_ev[k], exp_ev[k]);
    check(o_busy, 1'b0);
    $display("test %s done", name);
  endtask : end_test
  task automatic imm_store(input logic q, input logic priv);
    logic [31:0] a, d0, d1;
    a = xs();
    d0 = xs();
    d1 = xs();
    if (q) a[2:0] = 3'h0;
    i_privileged <= priv;
    send({3'h0, `BSC_OP_STORE_IMM, 1'b1, 14'h0, q ? `BSC_LEN_QWORD : `BSC_LEN_DWORD});
    send(32'h0);
    send(a);
    send(d0);
    if (q) send(d1);
    idle(1);
    exp_wr++;
    wait_wr();
    check(o_mem_addr, {a[31:2], 2'h0});
    check(fab_i.mem[a[31:2]], d0);
    if (q) check(fab_i.mem[a[31:2] + 30'h1], d1);
    check(fab_i.kind_reg[2:1], {priv, 1'b0});
  endtask : imm_store
  initial begin
    logic [9:0] idx;
    logic [19:0] ti;
    logic [31:0] e0, e1, ea;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 4; k++) imm_store(k[1], k[0]);
    end_test("immediate store");
    for (int p = 0; p < 2; p++) begin
      idx = (10'h10 + 10'(xs() % 1000)) & 10'h3fe;
      i_ctx_base <= xs() & 32'hfffffffc;
      i_privileged <= 1'b1;
      send({3'h0, `BSC_OP_STORE_IDX, 1'b0, p[0], 13'h0, `BSC_LEN_QWORD});
      send({20'h0, idx, 2'h0});
      e0 = xs();
      e1 = xs();
      send(e0);
      send(e1);
      idle(1);
      exp_wr++;
      wait_wr();
      ea = (p ? i_ctx_base : 32'h0) + {20'h0, idx, 2'h0};
      check(o_mem_addr, ea);
      check({fab_i.mem[ea[31:2] + 30'h1], fab_i.mem[ea[31:2]]}, {e1, e0});
      check(fab_i.kind_reg[1:0], {1'b1, p[0]});
    end
    end_test("status store");
    for (int pv = 1; pv >= 0; pv--) begin
      ti = 20'(xs());
      e0 = xs();
      e1 = xs();
      i_privileged <= pv[0];
      idle(2);
      send({3'h0, `BSC_OP_TT_UPDATE, 1'b1, 16'h0, 6'h03});
      send(e0);
      send({ti, 12'h0});
      send(e1);
      send(xs() & 32'hfffff000);
      idle(4);
      if (pv) begin
        exp_wr += 2;
        wait_wr();
        check(fab_i.tt[ti], e0);
        check(fab_i.tt[20'(ti + 20'h1)], e1);
      end else exp_ev[1]++;
    end
    end_test("table update");
    send({3'h0, `BSC_OP_SW_INT, 23'h0});
    exp_ev[0]++;
    imm_store(1'b1, 1'b1);
    send({3'h1, `BSC_OP_SW_INT, 23'h0});
    end_test("user interrupt");
    for (int h = 1; h >= 0; h--) begin
      send({3'h0, `BSC_OP_FLUSH_HOLD, 22'h0, h[0]});
      idle(2);
      check(o_flush_hold, h[0]);
      @(posedge i_clk);
      i_reg_flush_req <= 1'b1;
      i_io_flush_req <= 1'b1;
      idle(3);
      if (!h) exp_ev[2]++;
      if (!h) exp_ev[3]++;
    end
    end_test("flush hold");
    finish_test();
  end
endmodule : bsc_ctrl_cmd_tb
